// >>> logic/upper_gpio_pkg.sv
/*
 * Shared constants and carrier types for the upper pin multiplexer.
 * Assumes one 20 MHz clock and an APB master on the same clock.
 */
`default_nettype none

package upper_gpio_pkg;

   // ------------------------------------------------------------
   // Pin range
   // ------------------------------------------------------------
   localparam int PIN_BASE = 18;
   localparam int NUM_PINS = 18;
   localparam int NUM_SEL_PINS = 14;

   // Pin indices relative to PIN_BASE
   localparam int IDX_REQUEST = 0;
   localparam int IDX_DONE = 1;
   localparam int IDX_FRAME = 2;
   localparam int IDX_RX_ADDR0 = 6;
   localparam int IDX_RX_ADDR1 = 7;
   localparam int IDX_NO_ALT = 8;
   localparam int IDX_BUS_ADDR22 = 9;
   localparam int IDX_FINISHED = 13;
   localparam int BUS_ADDR_BITS = 4;

   // ------------------------------------------------------------
   // Function select codes
   // ------------------------------------------------------------
   localparam logic [1:0] FUNC_GPIO = 2'h0;
   localparam logic [1:0] FUNC_ALT1 = 2'h1;
   localparam logic [1:0] FUNC_ALT2 = 2'h2;

   // ------------------------------------------------------------
   // Register map (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] ADDR_FUNC_SEL = 8'h00;
   localparam logic [7:0] ADDR_DIR = 8'h04;
   localparam logic [7:0] ADDR_DOUT = 8'h08;
   localparam logic [7:0] ADDR_DIN = 8'h0c;
   localparam logic [7:0] ADDR_XFER_STATUS = 8'h10;

   localparam logic [31:0] FUNC_SEL_RESET = 32'h0000_0000;
   localparam logic [17:0] DIR_RESET = 18'h0_0000;
   localparam logic [17:0] DOUT_RESET = 18'h0_0000;
   // Pins 21..23 and 26 have no select field here
   localparam logic [31:0] FUNC_SEL_MASK = 32'h0ffc_f03f;
   localparam int XFER_FINISHED_BIT = 0;

   typedef struct packed {
      logic [1:0] sel;
      logic gpio_out;
      logic gpio_oe;
      logic alt1_out;
      logic alt1_oe;
      logic alt2_out;
      logic alt2_oe;
   } pin_ctrl_type;

endpackage

`default_nettype wire

// >>> logic/pin_mux_cell.sv
/*
 * One pad's output multiplexer with registered pad drive.
 * Assumes the select code and source signals are on pclk.
 */
`default_nettype none

module pin_mux_cell (
   input wire logic pclk,
   input wire logic presetn,
   input wire upper_gpio_pkg::pin_ctrl_type ctrl,
   output logic pad_out,
   output logic pad_oe
);

   logic pad_out_nxt;
   logic pad_oe_nxt;

   always_comb begin
      pad_out_nxt = ctrl.gpio_out;
      pad_oe_nxt = ctrl.gpio_oe;
      unique case (ctrl.sel)
         upper_gpio_pkg::FUNC_ALT1: begin
            pad_out_nxt = ctrl.alt1_out;
            pad_oe_nxt = ctrl.alt1_oe;
         end
         upper_gpio_pkg::FUNC_ALT2: begin
            pad_out_nxt = ctrl.alt2_out;
            pad_oe_nxt = ctrl.alt2_oe;
         end
         default: begin
            // Code 3 is not a function; it behaves as plain I/O
            pad_out_nxt = ctrl.gpio_out;
            pad_oe_nxt = ctrl.gpio_oe;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end else begin
         pad_out <= pad_out_nxt;
         pad_oe <= pad_oe_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> logic/upper_gpio_pin_mux.sv
/*
 * Pin multiplexer for general purpose pins 18 to 35 with APB registers,
 * external transfer handshake pins and the transfer finished counter.
 * Assumes pads resolve level from pad_out/pad_oe outside, DMA engine and
 * memory controller signals are on pclk, and pad inputs are asynchronous.
 */
`default_nettype none

module upper_gpio_pin_mux #(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [17:0] pad_in,
   output logic [17:0] pad_out,
   output logic [17:0] pad_oe,
   input wire logic [1:0] cell_rx_phy_addr,
   input wire logic active_channel_code,
   input wire logic [3:0] ext_bus_addr_high,
   input wire logic frame_start_marker,
   input wire logic desc_start,
   input wire logic [COUNT_WIDTH-1:0] desc_byte_count,
   input wire logic byte_moved,
   output logic ext_transfer_request_n,
   output logic ext_device_done_n,
   output logic debug_ctrl_reset_n
);

   // ------------------------------------------------------------
   // Parameter check
   // ------------------------------------------------------------
   if (COUNT_WIDTH < 1 || COUNT_WIDTH > 31) begin : g_bad_width
      $error("COUNT_WIDTH must be 1 to 31");
   end

   function automatic logic [1:0] sel_of(input logic [31:0] sel_reg, input int idx);
      sel_of = sel_reg[2*idx +: 2];
   endfunction

   // ------------------------------------------------------------
   // Pad input synchronisers
   // ------------------------------------------------------------
   logic [17:0] sync1_r;
   logic [17:0] sync2_r;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 18'h0_0000;
         sync2_r <= 18'h0_0000;
      end else begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   // ------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------
   logic [31:0] func_sel_r;
   logic [31:0] func_sel_nxt;
   logic [17:0] dir_r;
   logic [17:0] dir_nxt;
   logic [17:0] dout_r;
   logic [17:0] dout_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic finished_r;
   logic setup;
   logic access_wr;
   logic mapped;

   assign setup = psel && !penable;
   assign access_wr = psel && penable && pwrite;
   assign mapped = (paddr == upper_gpio_pkg::ADDR_FUNC_SEL) || (paddr == upper_gpio_pkg::ADDR_DIR) ||
                   (paddr == upper_gpio_pkg::ADDR_DOUT) || (paddr == upper_gpio_pkg::ADDR_DIN) ||
                   (paddr == upper_gpio_pkg::ADDR_XFER_STATUS);
   // Zero wait states: read data is captured in the setup cycle
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = prdata_r;

   always_comb begin
      func_sel_nxt = func_sel_r;
      dir_nxt = dir_r;
      dout_nxt = dout_r;
      prdata_nxt = prdata_r;
      if (access_wr) begin
         unique case (paddr)
            upper_gpio_pkg::ADDR_FUNC_SEL: func_sel_nxt = pwdata & upper_gpio_pkg::FUNC_SEL_MASK;
            upper_gpio_pkg::ADDR_DIR: dir_nxt = pwdata[17:0];
            upper_gpio_pkg::ADDR_DOUT: dout_nxt = pwdata[17:0];
            default: begin
               // Read-only and unmapped addresses ignore writes
               dout_nxt = dout_r;
            end
         endcase
      end
      if (setup) begin
         unique case (paddr)
            upper_gpio_pkg::ADDR_FUNC_SEL: prdata_nxt = func_sel_r;
            upper_gpio_pkg::ADDR_DIR: prdata_nxt = {14'h0000, dir_r};
            upper_gpio_pkg::ADDR_DOUT: prdata_nxt = {14'h0000, dout_r};
            upper_gpio_pkg::ADDR_DIN: prdata_nxt = {14'h0000, sync2_r};
            upper_gpio_pkg::ADDR_XFER_STATUS: prdata_nxt = {31'h0000_0000, finished_r};
            default: prdata_nxt = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         func_sel_r <= upper_gpio_pkg::FUNC_SEL_RESET;
         dir_r <= upper_gpio_pkg::DIR_RESET;
         dout_r <= upper_gpio_pkg::DOUT_RESET;
         prdata_r <= 32'h0000_0000;
      end else begin
         func_sel_r <= func_sel_nxt;
         dir_r <= dir_nxt;
         dout_r <= dout_nxt;
         prdata_r <= prdata_nxt;
      end
   end

   // ------------------------------------------------------------
   // Descriptor byte counter
   // ------------------------------------------------------------
   logic [COUNT_WIDTH-1:0] remain_r;
   logic [COUNT_WIDTH-1:0] remain_nxt;
   logic active_r;
   logic active_nxt;
   logic finished_nxt;

   always_comb begin
      remain_nxt = remain_r;
      active_nxt = active_r;
      finished_nxt = finished_r;
      if (desc_start) begin
         remain_nxt = desc_byte_count;
         active_nxt = 1'b1;
         finished_nxt = 1'b0;
      end else if (active_r && remain_r == '0) begin
         // Zero-length descriptor finishes at once
         active_nxt = 1'b0;
         finished_nxt = 1'b1;
      end else if (active_r && byte_moved) begin
         remain_nxt = remain_r - 1'b1;
         if (remain_r == COUNT_WIDTH'(1)) begin
            active_nxt = 1'b0;
            finished_nxt = 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         remain_r <= '0;
         active_r <= 1'b0;
         finished_r <= 1'b0;
      end else begin
         remain_r <= remain_nxt;
         active_r <= active_nxt;
         finished_r <= finished_nxt;
      end
   end

   // ------------------------------------------------------------
   // Per-pin source selection
   // ------------------------------------------------------------
   localparam int NUM_PINS_L = upper_gpio_pkg::NUM_PINS;
   upper_gpio_pkg::pin_ctrl_type ctrl [NUM_PINS_L];

   always_comb begin
      for (int i = 0; i < NUM_PINS_L; i++) begin
         ctrl[i].sel = (i < upper_gpio_pkg::NUM_SEL_PINS) ? sel_of(func_sel_r, i) : upper_gpio_pkg::FUNC_GPIO;
         ctrl[i].gpio_out = dout_r[i];
         ctrl[i].gpio_oe = dir_r[i];
         ctrl[i].alt1_out = 1'b0;
         ctrl[i].alt1_oe = 1'b0;
         ctrl[i].alt2_out = 1'b0;
         ctrl[i].alt2_oe = 1'b0;
      end
      ctrl[upper_gpio_pkg::IDX_FRAME].alt1_out = frame_start_marker;
      ctrl[upper_gpio_pkg::IDX_FRAME].alt1_oe = 1'b1;
      ctrl[upper_gpio_pkg::IDX_RX_ADDR0].alt1_out = cell_rx_phy_addr[0];
      ctrl[upper_gpio_pkg::IDX_RX_ADDR0].alt1_oe = 1'b1;
      ctrl[upper_gpio_pkg::IDX_RX_ADDR1].alt1_out = cell_rx_phy_addr[1];
      ctrl[upper_gpio_pkg::IDX_RX_ADDR1].alt1_oe = 1'b1;
      ctrl[upper_gpio_pkg::IDX_RX_ADDR1].alt2_out = active_channel_code;
      ctrl[upper_gpio_pkg::IDX_RX_ADDR1].alt2_oe = 1'b1;
      for (int b = 0; b < upper_gpio_pkg::BUS_ADDR_BITS; b++) begin
         ctrl[upper_gpio_pkg::IDX_BUS_ADDR22 + b].alt1_out = ext_bus_addr_high[b];
         ctrl[upper_gpio_pkg::IDX_BUS_ADDR22 + b].alt1_oe = 1'b1;
      end
      // Finished is active low: high while a transfer is pending
      ctrl[upper_gpio_pkg::IDX_FINISHED].alt1_out = !finished_r;
      ctrl[upper_gpio_pkg::IDX_FINISHED].alt1_oe = 1'b1;
      // Request, done and debug reset alternates are inputs: pad stays released
   end

   for (genvar g = 0; g < upper_gpio_pkg::NUM_PINS; g++) begin : g_cell
      pin_mux_cell u_cell (
         .pclk(pclk),
         .presetn(presetn),
         .ctrl(ctrl[g]),
         .pad_out(pad_out[g]),
         .pad_oe(pad_oe[g])
      );
   end

   // ------------------------------------------------------------
   // Alternate inputs toward the core
   // ------------------------------------------------------------
   logic req_n_nxt;
   logic done_n_nxt;
   logic dbg_rst_n_nxt;

   // Deselected inputs read inactive high so the core never sees a stray request
   always_comb begin
      req_n_nxt = (sel_of(func_sel_r, upper_gpio_pkg::IDX_REQUEST) == upper_gpio_pkg::FUNC_ALT1) ?
                  sync2_r[upper_gpio_pkg::IDX_REQUEST] : 1'b1;
      done_n_nxt = (sel_of(func_sel_r, upper_gpio_pkg::IDX_DONE) == upper_gpio_pkg::FUNC_ALT1) ?
                   sync2_r[upper_gpio_pkg::IDX_DONE] : 1'b1;
      dbg_rst_n_nxt = (sel_of(func_sel_r, upper_gpio_pkg::IDX_FINISHED) == upper_gpio_pkg::FUNC_ALT2) ?
                      sync2_r[upper_gpio_pkg::IDX_FINISHED] : 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_transfer_request_n <= 1'b1;
         ext_device_done_n <= 1'b1;
         debug_ctrl_reset_n <= 1'b1;
      end else begin
         ext_transfer_request_n <= req_n_nxt;
         ext_device_done_n <= done_n_nxt;
         debug_ctrl_reset_n <= dbg_rst_n_nxt;
      end
   end

endmodule

`default_nettype wire

// >>> tb/pad_partner.sv
/* Board side of pins 18 to 35: external transfer device, debug reset source, loose pads.
   Assumes the bench commands which pads it drives and to what level. */
`default_nettype none
module pad_partner (
   input wire logic pclk,
   input wire logic [17:0] pad_out,
   input wire logic [17:0] pad_oe,
   input wire logic [17:0] ext_drive,
   input wire logic [17:0] ext_level,
   output logic [17:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ns;
   logic toggle_r = 1'b0;
   always @(posedge pclk) toggle_r <= ~toggle_r;
   // Undriven pads toggle so a stale value never looks valid; 18, 19 and 31 have pull-ups
   always_comb begin
      for (int i = 0; i < 18; i++) begin
         if (pad_oe[i])
            pad_in[i] = pad_out[i];
         else if (ext_drive[i])
            pad_in[i] = ext_level[i]; // Request and done asserted low here
         else if (i == 0 || i == 1 || i == 13)
            pad_in[i] = 1'b1;
         else
            pad_in[i] = toggle_r;
      end
   end
endmodule
`default_nettype wire

// >>> tb/upper_gpio_sva.sv
/* Port checker for the upper pin multiplexer.
   Assumes zero wait APB and registered pads; bound below to every instance. */
`default_nettype none
module upper_gpio_sva #(
   parameter int COUNT_WIDTH = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [17:0] pad_in,
   input wire logic [17:0] pad_out,
   input wire logic [17:0] pad_oe,
   input wire logic [1:0] cell_rx_phy_addr,
   input wire logic active_channel_code,
   input wire logic desc_start,
   input wire logic [COUNT_WIDTH-1:0] desc_byte_count,
   input wire logic byte_moved,
   input wire logic ext_transfer_request_n,
   input wire logic ext_device_done_n,
   input wire logic debug_ctrl_reset_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadow of the select register, snooped from the bus
   logic [31:0] sel_r;
   logic [31:0] sel_nxt;
   always_comb begin
      sel_nxt = sel_r;
      if (psel && penable && pwrite && paddr == upper_gpio_pkg::ADDR_FUNC_SEL)
         sel_nxt = pwdata & upper_gpio_pkg::FUNC_SEL_MASK;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         sel_r <= upper_gpio_pkg::FUNC_SEL_RESET;
      else
         sel_r <= sel_nxt;
   end
   property p_rx0;
      $past(sel_r[13:12]) == 2'h1 |-> pad_oe[6] && pad_out[6] == $past(cell_rx_phy_addr[0]);
   endproperty
   a_rx0: assert property (p_rx0) else $error("pin 24 alternate wrong");
   property p_chan;
      $past(sel_r[15:14]) == 2'h2 |-> pad_oe[7] && pad_out[7] == $past(active_channel_code);
   endproperty
   a_chan: assert property (p_chan) else $error("pin 25 second alternate wrong");
   property p_fin;
      (sel_r[27:26] == 2'h1 && desc_start && desc_byte_count == 3 ##1 (byte_moved && !desc_start) [*3])
         |=> pad_out[13] ##1 !pad_out[13];
   endproperty
   a_fin: assert property (p_fin) else $error("finished pin timing wrong");
   property p_req;
      ext_transfer_request_n == ($past(sel_r[1:0]) != 2'h1 || $past(pad_in[0], 3));
   endproperty
   a_req: assert property (p_req) else $error("request output wrong");
   property p_done;
      ext_device_done_n == ($past(sel_r[3:2]) != 2'h1 || $past(pad_in[1], 3));
   endproperty
   a_done: assert property (p_done) else $error("done output wrong");
   property p_dbg;
      debug_ctrl_reset_n == ($past(sel_r[27:26]) != 2'h2 || $past(pad_in[13], 3));
   endproperty
   a_dbg: assert property (p_dbg) else $error("debug reset output wrong");
   property p_rst;
      !$past(presetn) |-> pad_oe == 18'h0 && ext_transfer_request_n && ext_device_done_n && debug_ctrl_reset_n;
   endproperty
   a_rst: assert property (p_rst) else $error("pads not idle after reset");
   property p_apb;
      pready && pslverr == (psel && penable && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0c, 8'h10}));
   endproperty
   a_apb: assert property (p_apb) else $error("bus answer wrong");
   c_fin: cover property (pad_oe[13] && !pad_out[13]);
   c_req: cover property (!ext_transfer_request_n && !ext_device_done_n);
   c_err: cover property (pslverr);
endmodule
bind upper_gpio_pin_mux upper_gpio_sva #(.COUNT_WIDTH(COUNT_WIDTH)) upper_gpio_sva_inst (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .cell_rx_phy_addr,
   .active_channel_code, .desc_start, .desc_byte_count, .byte_moved, .ext_transfer_request_n,
   .ext_device_done_n, .debug_ctrl_reset_n);
`default_nettype wire

// >>> tb/testbench.sv
/* Self-checking bench for the upper pin multiplexer.
   Assumes the board model on the pads and the bound checker. */
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, ext_transfer_request_n, ext_device_done_n, debug_ctrl_reset_n;
   logic [17:0] pad_in, pad_out, pad_oe, ext_drive = 18'h0, ext_level = 18'h0;
   logic [1:0] cell_rx_phy_addr = 2'h1;
   logic [3:0] ext_bus_addr_high = 4'ha;
   logic active_channel_code = 1'b1, frame_start_marker = 1'b1, desc_start = 1'b0, byte_moved = 1'b0;
   logic [15:0] desc_byte_count = 16'h0;
   int mismatches = 0, comparisons = 0, cycles = 0;
   always #25 pclk = ~pclk;
   upper_gpio_pin_mux #(.COUNT_WIDTH(16)) upper_gpio_pin_mux_inst (.pclk, .presetn, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .pad_in, .pad_out, .pad_oe, .cell_rx_phy_addr,
      .active_channel_code, .ext_bus_addr_high, .frame_start_marker, .desc_start, .desc_byte_count,
      .byte_moved, .ext_transfer_request_n, .ext_device_done_n, .debug_ctrl_reset_n);
   pad_partner pad_partner_inst (.pclk, .pad_out, .pad_oe, .ext_drive, .ext_level, .pad_in);
   task summarize;
      if (mismatches == 0 && comparisons > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task settle(input int n);
      repeat (n) @(posedge pclk);
      @(negedge pclk);
   endtask
   task t_reset;
      chk("pad_oe", 32'h0, {14'h0, pad_oe});
      chk("inputs", 32'h7, {ext_transfer_request_n, ext_device_done_n, debug_ctrl_reset_n});
      apb(1'b0, 8'h00, 32'h0);
      chk("func_sel", 32'h0, rd);
   endtask
   task t_regs;
      apb(1'b1, 8'h00, 32'hffff_ffff);
      apb(1'b0, 8'h00, 32'h0);
      chk("func_sel", 32'h0ffc_f03f, rd);
      apb(1'b1, 8'h14, 32'h1);
      chk("pslverr", 32'h1, {31'h0, err});
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped", 32'h0, rd);
   endtask
   task t_gpio;
      apb(1'b1, 8'h04, 32'h3ffff);
      apb(1'b1, 8'h08, 32'h2b5a1);
      settle(1);
      chk("pad_out", 32'h2b5a1, {14'h0, pad_out});
      chk("pad_oe", 32'h3ffff, {14'h0, pad_oe});
      apb(1'b1, 8'h04, 32'h0);
      ext_drive <= 18'h3ffff;
      ext_level <= 18'h14c3e;
      settle(4);
      apb(1'b0, 8'h0c, 32'h0);
      chk("din", 32'h14c3e, rd);
      ext_level <= 18'h3ffff;
   endtask
   task t_alt;
      apb(1'b1, 8'h00, 32'h0154_9010);
      settle(1);
      chk("alt oe", 32'h7f, {pad_oe[12:9], pad_oe[7:6], pad_oe[2]});
      chk("alt out", 32'h57, {pad_out[12:9], pad_out[7:6], pad_out[2]});
      @(posedge pclk);
      cell_rx_phy_addr <= 2'h2;
      active_channel_code <= 1'b0;
      ext_bus_addr_high <= 4'h5;
      frame_start_marker <= 1'b0;
      settle(1);
      chk("alt out", 32'h28, {pad_out[12:9], pad_out[7:6], pad_out[2]});
      apb(1'b1, 8'h00, 32'h0000_4000);
      settle(1);
      chk("pin 25", 32'h5, {pad_oe[7:6], pad_out[7]});
   endtask
   task t_dma;
      apb(1'b1, 8'h00, 32'h0400_0005);
      @(posedge pclk);
      ext_level <= 18'h3fffc;
      settle(3);
      chk("handshake", 32'h3, {ext_transfer_request_n, ext_device_done_n, pad_oe[1:0], pad_oe[13], pad_out[13]});
      @(posedge pclk);
      desc_start <= 1'b1;
      desc_byte_count <= 16'h3;
      @(posedge pclk);
      desc_start <= 1'b0;
      byte_moved <= 1'b1;
      repeat (3) @(posedge pclk);
      byte_moved <= 1'b0;
      @(negedge pclk);
      chk("finished early", 32'h1, {31'h0, pad_out[13]});
      @(negedge pclk);
      chk("finished", 32'h0, {31'h0, pad_out[13]});
      apb(1'b0, 8'h10, 32'h0);
      chk("status", 32'h1, {31'h0, rd[0]});
   endtask
   task t_dbg;
      apb(1'b1, 8'h00, 32'h0800_0000);
      @(posedge pclk);
      ext_level <= 18'h1dfff;
      settle(3);
      chk("debug reset", 32'h0, {30'h0, debug_ctrl_reset_n, pad_oe[13]});
      @(posedge pclk);
      presetn <= 1'b0;
      @(negedge pclk);
      chk("reset pads", 32'h1, {13'h0, pad_oe, debug_ctrl_reset_n});
      @(posedge pclk);
      presetn <= 1'b1;
      settle(2);
      chk("after reset", 32'h1, {13'h0, pad_oe, debug_ctrl_reset_n});
      apb(1'b0, 8'h00, 32'h0);
      chk("func_sel after reset", 32'h0, rd);
   endtask
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         summarize();
      end
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      settle(3);
      t_reset();
      t_regs();
      t_gpio();
      t_alt();
      t_dma();
      t_dbg();
      summarize();
   end
endmodule
`default_nettype wire
